// [rtl/zwwsd_cfg.svh]
// Purpose: constants for the zone write wait-state decoder
// Assumes: AXI4-Lite byte addresses, 32-bit data, 125 MHz aclk
// Notes: timing clock is aclk divided by ZW_TIM_DIV as an enable pulse
//
// Contract
// RULE1: read trail code 11 gives three cycles, six doubled; default.
// RULE2: write lead code at bits 6:5 gives zero to three cycles.
// RULE3: doubling makes write lead two, four or six; code 00 stays zero.
// RULE4: write active wait code at bits 4:2; 000 adds none, 001 one.
// RULE5: write active phase lasts one base cycle plus its wait states.
// RULE6: doubling doubles write active wait states; 001 then adds two.
// RULE7: read trail code at bits 8:7, timing clock cycles, doubled option.
// RULE8: write access runs lead, then active, then trail phase in order.
`ifndef ZWWSD_CFG_SVH
`define ZWWSD_CFG_SVH

// register byte addresses
`define ZW_ADDR_TIMING 8'h00
`define ZW_ADDR_CONFIG 8'h04
`define ZW_ADDR_CONTROL 8'h08
`define ZW_ADDR_STATUS 8'h0C
`define ZW_ADDR_DECODE 8'h10

// timing register field positions
`define ZW_RDTR_HI 8
`define ZW_RDTR_LO 7
`define ZW_WRLD_HI 6
`define ZW_WRLD_LO 5
`define ZW_WRAC_HI 4
`define ZW_WRAC_LO 2
`define ZW_WRTR_HI 1
`define ZW_WRTR_LO 0

// reset values: every code at its largest, doubling on
`define ZW_TIMING_RST 9'h1FF
`define ZW_DOUBLE_RST 1'h1

// config and control bits
`define ZW_CFG_DOUBLE_BIT 0
`define ZW_CTL_START_BIT 0

// timing clock divider: aclk cycles per timing clock cycle
`define ZW_TIM_DIV 8'h02

// bus responses
`define ZW_RESP_OKAY 2'h0
`define ZW_RESP_SLVERR 2'h2

`endif

// [rtl/zwwsd_pkg.sv]
// Purpose: types for the zone write wait-state decoder
// Assumes: AXI4-Lite with 8-bit addresses
// Notes: decode helper shared by all wait fields
package zwwsd_pkg;

  typedef enum logic [1:0] {
    ZW_IDLE,
    ZW_LEAD,
    ZW_ACTIVE,
    ZW_TRAIL
  } zwwsd_phase_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } zwwsd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } zwwsd_axi_rsp_t;

  typedef struct packed {
    logic lead;
    logic active;
    logic trail;
    logic busy;
  } zwwsd_phase_out_t;

  // wait-state count of a field code, doubled on request
  function automatic logic [3:0] zwwsd_waits(input logic [2:0] code,
                                              input logic dbl);
    zwwsd_waits = dbl ? {code, 1'h0} : {1'h0, code};
  endfunction : zwwsd_waits

endpackage : zwwsd_pkg

// [rtl/zwwsd_top.sv]
// Purpose: decode zone wait fields and sequence one write access
// Assumes: inputs synchronous to aclk, AXI4-Lite master well behaved
// Notes: phase lengths are counted in timing clock enable pulses
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "zwwsd_cfg.svh"

module zwwsd_top
  import zwwsd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire zwwsd_axi_req_t axi_req,
  output zwwsd_axi_rsp_t axi_rsp,
  output zwwsd_phase_out_t phase_out
);

  // all state in one record: one comb copy, one register
  typedef struct packed {
    zwwsd_axi_rsp_t rsp;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [8:0] timing;
    logic dbl;
    logic start_pend;
    logic [7:0] div_cnt;
    zwwsd_phase_t phase;
    logic [3:0] cnt;
    zwwsd_phase_out_t po;
  } zwwsd_state_t;

  // registered state and its next value
  zwwsd_state_t s;
  zwwsd_state_t next_s;
  // timing clock enable and phase lengths counted in its cycles
  logic tick;
  logic [3:0] lead_cyc;
  logic [3:0] active_cyc;
  logic [3:0] trail_cyc;
  logic [3:0] rd_trail_cyc;

  // decoded phase lengths from the live timing fields; a timing write
  // during an access only affects phases that have not started yet
  assign lead_cyc = zwwsd_waits({1'h0, s.timing[`ZW_WRLD_HI:`ZW_WRLD_LO]},
                                s.dbl); // RULE2 RULE3
  assign active_cyc = 4'h1 + zwwsd_waits(
    s.timing[`ZW_WRAC_HI:`ZW_WRAC_LO], s.dbl); // RULE4 RULE5 RULE6
  // write trail decodes like lead; read trail is shown, not sequenced
  assign trail_cyc = zwwsd_waits({1'h0, s.timing[`ZW_WRTR_HI:`ZW_WRTR_LO]},
                                 s.dbl);
  assign rd_trail_cyc = zwwsd_waits(
    {1'h0, s.timing[`ZW_RDTR_HI:`ZW_RDTR_LO]}, s.dbl); // RULE1 RULE7

  // timing clock enable, one aclk pulse per divider period; it runs
  // free from reset, so a start may wait up to one period for its tick
  assign tick = (s.div_cnt == (`ZW_TIM_DIV - 8'h01));

  // next state of bus slave, registers and sequencer
  always_comb begin
    next_s = s;
    next_s.div_cnt = tick ? 8'h00 : s.div_cnt + 8'h01;
    // write response handshake
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'h0;
    end
    // address and data captured independently
    if (s.rsp.awready && axi_req.awvalid) begin
      next_s.aw_have = 1'h1;
      next_s.aw_addr = axi_req.awaddr;
    end
    if (s.rsp.wready && axi_req.wvalid) begin
      next_s.w_have = 1'h1;
      next_s.w_data = axi_req.wdata;
      next_s.w_strb = axi_req.wstrb;
    end
    // commit once both halves are held and the response slot is free;
    // a response still waiting for bready holds the next write back
    if (s.aw_have && s.w_have && !s.rsp.bvalid) begin
      next_s.aw_have = 1'h0;
      next_s.w_have = 1'h0;
      next_s.rsp.bvalid = 1'h1;
      next_s.rsp.bresp = `ZW_RESP_OKAY;
      unique case (s.aw_addr)
        `ZW_ADDR_TIMING: begin
          // only bits 8:0 exist; strobes above byte 1 change nothing
          if (s.w_strb[0]) begin
            next_s.timing[7:0] = s.w_data[7:0];
          end
          if (s.w_strb[1]) begin
            next_s.timing[8] = s.w_data[8];
          end
        end
        `ZW_ADDR_CONFIG: begin
          // one doubling bit serves every wait field at once
          if (s.w_strb[0]) begin
            next_s.dbl = s.w_data[`ZW_CFG_DOUBLE_BIT];
          end
        end
        `ZW_ADDR_CONTROL: begin
          // start ignored while an access is pending or running
          if (s.w_strb[0] && s.w_data[`ZW_CTL_START_BIT] &&
              !s.po.busy) begin
            next_s.start_pend = 1'h1;
          end
        end
        `ZW_ADDR_STATUS, `ZW_ADDR_DECODE: begin
          next_s.rsp.bresp = `ZW_RESP_OKAY; // read-only, write dropped
        end
        default: begin
          // unmapped address: nothing changes, error response
          next_s.rsp.bresp = `ZW_RESP_SLVERR;
        end
      endcase
    end
    // a held half keeps its ready low until the commit frees it
    next_s.rsp.awready = !next_s.aw_have;
    next_s.rsp.wready = !next_s.w_have;

    // read channel: arready stays low until the data is taken
    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'h0;
      next_s.rsp.arready = 1'h1;
    end
    // read data built from the state before this edge
    if (s.rsp.arready && axi_req.arvalid) begin
      next_s.rsp.arready = 1'h0;
      next_s.rsp.rvalid = 1'h1;
      next_s.rsp.rresp = `ZW_RESP_OKAY;
      next_s.rsp.rdata = 32'h0000_0000;
      unique case (axi_req.araddr)
        `ZW_ADDR_TIMING: next_s.rsp.rdata[8:0] = s.timing;
        `ZW_ADDR_CONFIG: next_s.rsp.rdata[`ZW_CFG_DOUBLE_BIT] = s.dbl;
        `ZW_ADDR_CONTROL: next_s.rsp.rdata = 32'h0000_0000;
        `ZW_ADDR_STATUS: begin
          next_s.rsp.rdata[0] = s.po.busy;
          next_s.rsp.rdata[2:1] = s.phase;
          next_s.rsp.rdata[11:8] = s.cnt;
        end
        `ZW_ADDR_DECODE: begin
          next_s.rsp.rdata[3:0] = lead_cyc;
          next_s.rsp.rdata[11:8] = active_cyc;
          next_s.rsp.rdata[19:16] = trail_cyc;
          next_s.rsp.rdata[27:24] = rd_trail_cyc;
        end
        default: begin
          // unmapped read answers zero with an error
          next_s.rsp.rresp = `ZW_RESP_SLVERR;
        end
      endcase
    end

    // write access sequencer, one step per timing clock cycle
    if (tick) begin
      unique case (s.phase)
        // a pending start opens lead, or active when lead is zero
        ZW_IDLE: begin
          if (s.start_pend) begin
            next_s.start_pend = 1'h0;
            if (lead_cyc != 4'h0) begin
              next_s.phase = ZW_LEAD; // RULE8
              next_s.cnt = lead_cyc;
            end else begin
              next_s.phase = ZW_ACTIVE; // RULE8
              next_s.cnt = active_cyc;
            end
          end
        end
        // count lead down, then load the active length
        ZW_LEAD: begin
          if (s.cnt <= 4'h1) begin
            next_s.phase = ZW_ACTIVE; // RULE8
            next_s.cnt = active_cyc;
          end else begin
            next_s.cnt = s.cnt - 4'h1;
          end
        end
        // active lasts at least its base cycle; trail zero ends here
        ZW_ACTIVE: begin
          if (s.cnt <= 4'h1) begin
            next_s.phase = (trail_cyc != 4'h0) ? ZW_TRAIL : ZW_IDLE; // RULE8
            next_s.cnt = trail_cyc;
          end else begin
            next_s.cnt = s.cnt - 4'h1;
          end
        end
        // trail closes the access
        ZW_TRAIL: begin
          if (s.cnt <= 4'h1) begin
            next_s.phase = ZW_IDLE;
            next_s.cnt = 4'h0;
          end else begin
            next_s.cnt = s.cnt - 4'h1;
          end
        end
      endcase
    end
    // phase outputs follow the registered phase
    next_s.po.lead = (next_s.phase == ZW_LEAD);
    next_s.po.active = (next_s.phase == ZW_ACTIVE);
    next_s.po.trail = (next_s.phase == ZW_TRAIL);
    next_s.po.busy = (next_s.phase != ZW_IDLE) || next_s.start_pend;
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // ready high, every code at its largest, doubling on
      s <= '0;
      s.rsp.awready <= 1'h1;
      s.rsp.wready <= 1'h1;
      s.rsp.arready <= 1'h1;
      s.timing <= `ZW_TIMING_RST; // RULE1
      s.dbl <= `ZW_DOUBLE_RST;
      s.phase <= ZW_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign axi_rsp = s.rsp;
  assign phase_out = s.po;

endmodule : zwwsd_top

// [verif/zone_write_wait_state_decode_tb.sv]
// Purpose: self-checking bench of the zone wait decoder
// Assumes: AXI4-Lite map of the cfg header
// Notes: phase lengths are two aclk per tick
`timescale 1ns/1ps
`include "zwwsd_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module zone_write_wait_state_decode_tb
  import zwwsd_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  zwwsd_axi_req_t req = '0;
  zwwsd_axi_rsp_t rsp;
  zwwsd_phase_out_t po;
  logic [7:0] ll, al, tl;
  logic [31:0] d;
  logic [1:0] r;
  int fails = 0, checked = 0, cyc = 0;
  always #4 aclk = ~aclk;
  zwwsd_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .phase_out(po));
  zwwsd_phase_mon mon (.aclk(aclk), .phase_out(po), .lead_len(ll),
    .act_len(al), .trail_len(tl));
  // one write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'h0;
  endtask : wr
  // one read: data taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'h0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'h0;
  endtask : rd
  // register values right after reset
  task automatic t_reset;
    rd(`ZW_ADDR_TIMING);
    `CHK(d[8:0], `ZW_TIMING_RST)
    rd(`ZW_ADDR_CONFIG);
    `CHK(d[0], `ZW_DOUBLE_RST)
    $display("test reset done");
  endtask : t_reset
  // every field code, with and without doubling
  task automatic t_decode;
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 8; c++) begin
        wr(`ZW_ADDR_CONFIG, 32'(k));
        wr(`ZW_ADDR_TIMING, {23'h0, c[1:0], c[1:0], c[2:0], c[1:0]});
        `CHK(r, `ZW_RESP_OKAY)
        rd(`ZW_ADDR_DECODE);
        `CHK(d[3:0], 4'((c % 4) << k))
        `CHK(d[11:8], 4'(1 + (c << k)))
        `CHK(d[19:16], 4'((c % 4) << k))
        `CHK(d[27:24], 4'((c % 4) << k))
      end
    end
    $display("test decode done");
  endtask : t_decode
  // one write access; lengths in aclk cycles, two per tick
  task automatic t_seq(input logic db, input logic [8:0] t,
    input logic [7:0] el, input logic [7:0] ea, input logic [7:0] et);
    wr(`ZW_ADDR_CONFIG, {31'h0, db});
    wr(`ZW_ADDR_TIMING, {23'h0, t});
    wr(`ZW_ADDR_CONTROL, 32'h1);
    rd(`ZW_ADDR_STATUS);
    `CHK(d[0], 1'h1)
    while (po.busy) @(posedge aclk);
    repeat (2) @(posedge aclk);
    `CHK(ll, el)
    `CHK(al, ea)
    `CHK(tl, et)
    rd(`ZW_ADDR_STATUS);
    `CHK(d[11:0], 12'h000)
    $display("test sequence done");
  endtask : t_seq
  // unmapped and read-only addresses
  task automatic t_bad;
    rd(8'h20);
    `CHK(r, `ZW_RESP_SLVERR)
    wr(8'h20, 32'h0);
    `CHK(r, `ZW_RESP_SLVERR)
    wr(`ZW_ADDR_STATUS, 32'h1);
    `CHK(r, `ZW_RESP_OKAY)
    rd(`ZW_ADDR_STATUS);
    `CHK(d[0], 1'h0)
    $display("test unmapped done");
  endtask : t_bad
  // counts, verdict and end of run
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end
  // main sequence; phase lengths are twice the tick counts
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_decode();
    t_seq(1'h1, 9'h185, 8'h00, 8'h06, 8'h04);
    t_seq(1'h0, 9'h060, 8'h06, 8'h02, 8'h00);
    t_bad();
    results();
  end
endmodule : zone_write_wait_state_decode_tb

// [verif/zwwsd_assertions.sv]
// Purpose: port checks of the zone wait decoder
// Assumes: one timing tick is two aclk cycles
// Notes: bound into zwwsd_top
`timescale 1ns/1ps
module zwwsd_chk
  import zwwsd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire zwwsd_axi_req_t axi_req,
  input wire zwwsd_axi_rsp_t axi_rsp,
  input wire zwwsd_phase_out_t phase_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ld, ac, tr;
  // short names for the phase levels
  assign ld = phase_out.lead;
  assign ac = phase_out.active;
  assign tr = phase_out.trail;
  // phase order and phase lengths
  a_one_phase: assert property ($onehot0({ld, ac, tr}))
    else $error("two phases at once");
  a_lead_active: assert property ($fell(ld) |-> ac)
    else $error("lead not followed by active");
  a_trail_after: assert property ($rose(tr) |-> $past(ac))
    else $error("trail without active");
  a_lead_tick: assert property ($rose(ld) |-> ld [*2])
    else $error("lead shorter than one tick");
  a_active_base: assert property ($rose(ac) |-> ac [*2])
    else $error("active shorter than base tick");
  a_active_max: assert property ($rose(ac) |-> ##[1:30] !ac)
    else $error("active too long");
  a_busy_span: assert property ((ld || ac || tr) |-> phase_out.busy)
    else $error("phase without busy");
  // bus answers arrive at fixed spacing
  a_read_ans: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid) else $error("late read answer");
  a_write_ans: assert property (axi_req.awvalid && axi_rsp.awready &&
    axi_req.wvalid && axi_rsp.wready |-> ##2 axi_rsp.bvalid)
    else $error("late write answer");
endmodule : zwwsd_chk

bind zwwsd_top zwwsd_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .phase_out(phase_out));

// [verif/zwwsd_phase_mon.sv]
// Purpose: far-side model timing each write phase
// Assumes: counts restart when busy rises
// Notes: lengths are in aclk cycles
`timescale 1ns/1ps
module zwwsd_phase_mon
  import zwwsd_pkg::*;
(
  input wire logic aclk,
  input wire zwwsd_phase_out_t phase_out,
  output logic [7:0] lead_len,
  output logic [7:0] act_len,
  output logic [7:0] trail_len
);
  logic bz = 1'h0;
  // clear on a new access, then count each phase level
  always_ff @(posedge aclk) begin
    bz <= phase_out.busy;
    if (phase_out.busy && !bz) begin
      lead_len <= 8'h00;
      act_len <= 8'h00;
      trail_len <= 8'h00;
    end else begin
      lead_len <= lead_len + 8'(phase_out.lead);
      act_len <= act_len + 8'(phase_out.active);
      trail_len <= trail_len + 8'(phase_out.trail);
    end
  end
endmodule : zwwsd_phase_mon
